// file: pkg/bus_ctl_pkg.sv
// bus_ctl_pkg: register map, field positions, reset values and bus carriers
// for the two-wire bus control word block.
// assumes an axi4-lite master with 32-bit data and an ADDR_W-bit address (8 bits by default).
package bus_ctl_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL_WORD = 8'h00;
	localparam logic [7:0] OFS_EVENT_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVENT_MASK   = 8'h14;
	localparam logic [7:0] OFS_RX_DATA      = 8'h18;
	localparam logic [7:0] OFS_OWN_ADDR     = 8'h1c;

	// ----------------------------------------------------------------
	// control word field positions
	// ----------------------------------------------------------------
	localparam int BIT_ENABLE       = 0;
	localparam int BIT_MASTER       = 1;
	localparam int BIT_GCALL        = 2;
	localparam int BIT_INTERACTIVE  = 3;
	localparam int BIT_NACK         = 4;
	localparam int BIT_RESERVED5    = 5;
	localparam int BIT_CLK_OUT      = 6;
	localparam int BIT_DATA_OUT     = 7;
	localparam int BIT_CLK_LEVEL    = 8;
	localparam int BIT_DATA_LEVEL   = 9;
	localparam int BIT_SW_OVERRIDE  = 10;

	// writable bits of the control word: 0..7 and 10
	localparam logic [31:0] CTRL_WR_MASK  = 32'h0000_04ff;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [6:0]  OWN_ADDR_RESET = 7'h2a;

	// ----------------------------------------------------------------
	// event bits
	// ----------------------------------------------------------------
	localparam int EV_BYTE_RX   = 0;
	localparam int EV_ADDR_HIT  = 1;
	localparam int EV_GCALL_HIT = 2;
	localparam int EV_STOP      = 3;
	localparam int NUM_EVENTS   = 4;

	// ----------------------------------------------------------------
	// timing: link clock period and sampling rate
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 8;
	localparam int LINK_PERIOD_NS = 125;
	localparam int LINK_CYCLES    = LINK_PERIOD_NS / CLK_PERIOD_NS;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// settings that steer the bus engine
	typedef struct packed {
		logic       enable;
		logic       master;
		logic       gcall_en;
		logic       interactive;
		logic       nack;
		logic [6:0] own_addr;
	} engine_cfg_t;

	// two-wire pin group: open-drain enables (active low) for clock and data
	typedef struct packed {
		logic clk_oe_n;
		logic data_oe_n;
	} line_drive_t;

endpackage

// file: rtl/bus_control_top.sv
// bus_control_top: control word, event registers and pin ownership for a
// two-wire bus peripheral, reached over axi4-lite.
// assumes line levels arrive from pads asynchronously; the pad cell ties
// the line low while an output enable (active low) is low.
`timescale 1ns/10ps
`default_nettype none

module bus_control_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               clk_line_i,
	output logic                    clk_line_o,
	output logic                    clk_line_oe_n,
	input  wire logic               data_line_i,
	output logic                    data_line_o,
	output logic                    data_line_oe_n,
	output logic                    irq
);
	import bus_ctl_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
		$error("ADDR_W must lie between 5 and 32");
	end

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0]           ctrl_q;
	logic [NUM_EVENTS-1:0] status_q;
	logic [NUM_EVENTS-1:0] mask_q;
	logic [6:0]            own_addr_q;
	logic [1:0]            clk_sync_q;
	logic [1:0]            data_sync_q;
	logic                  clk_lvl;
	logic                  data_lvl;
	logic                  aw_held_q;
	logic                  w_held_q;
	logic [ADDR_W-1:0]     aw_addr_q;
	logic [31:0]           w_data_q;
	logic [3:0]            w_strb_q;
	logic                  wr_go;
	logic [7:0]            wr_ofs;
	logic [31:0]           wr_bits;
	logic                  wr_hit;
	logic [7:0]            rd_ofs;
	logic [31:0]           rd_word;
	logic                  rd_hit;
	logic                  eng_pull;
	logic [NUM_EVENTS-1:0] eng_events;
	logic [7:0]            rx_byte;
	logic                  eng_busy;
	engine_cfg_t           cfg;
	line_drive_t           drive;

	// ----------------------------------------------------------------
	// pin synchronisers: two flops before any logic
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_sync_q  <= 2'b11;
			data_sync_q <= 2'b11;
		end else begin
			clk_sync_q  <= {clk_sync_q[0], clk_line_i};
			data_sync_q <= {data_sync_q[0], data_line_i};
		end
	end
	assign clk_lvl  = clk_sync_q[1];
	assign data_lvl = data_sync_q[1];

	// ----------------------------------------------------------------
	// axi4-lite write channel
	// ----------------------------------------------------------------
	// address and data are held independently, so either may come first
	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
	assign wr_go         = aw_held_q & w_held_q & ~s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_q <= 1'b0;
		end
	end

	// byte-lane merge against the old word is done per register below
	assign wr_ofs = {aw_addr_q[ADDR_W > 7 ? 7 : ADDR_W-1:2], 2'b00};
	always_comb begin
		wr_bits = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			wr_bits[i*8 +: 8] = {8{w_strb_q[i]}};
		end
	end
	assign wr_hit = (wr_ofs == OFS_CONTROL_WORD) |
	                (wr_ofs == OFS_EVENT_STATUS) |
	                (wr_ofs == OFS_EVENT_MASK) |
	                (wr_ofs == OFS_OWN_ADDR);

	// write response; unmapped offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control word; read-only bits never store
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_go && wr_ofs == OFS_CONTROL_WORD) begin
			// reserved bit 5 stores what software writes back
			ctrl_q <= (ctrl_q & ~(wr_bits & CTRL_WR_MASK)) |
			          (w_data_q & wr_bits & CTRL_WR_MASK);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			own_addr_q <= OWN_ADDR_RESET;
			mask_q     <= '0;
		end else if (wr_go && w_strb_q[0]) begin
			if (wr_ofs == OFS_OWN_ADDR)
				own_addr_q <= w_data_q[6:0];
			if (wr_ofs == OFS_EVENT_MASK)
				mask_q <= w_data_q[NUM_EVENTS-1:0];
		end
	end

	// ----------------------------------------------------------------
	// sticky events: a new event wins over write-one-to-clear
	// ----------------------------------------------------------------
	for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_event
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				status_q[e] <= 1'b0;
			end else if (eng_events[e]) begin
				status_q[e] <= 1'b1;
			end else if (wr_go && wr_ofs == OFS_EVENT_STATUS &&
			             w_strb_q[0] && w_data_q[e]) begin
				status_q[e] <= 1'b0;
			end
		end
	end
	assign irq = |(status_q & mask_q);

	// ----------------------------------------------------------------
	// axi4-lite read channel
	// ----------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_ofs = {s_axi_araddr[ADDR_W > 7 ? 7 : ADDR_W-1:2], 2'b00};

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		case (rd_ofs)
		OFS_CONTROL_WORD: begin
			rd_word = ctrl_q;
			rd_word[BIT_CLK_LEVEL]  = clk_lvl;
			rd_word[BIT_DATA_LEVEL] = data_lvl;
		end
		OFS_EVENT_STATUS: rd_word[NUM_EVENTS-1:0] = status_q;
		OFS_EVENT_MASK:   rd_word[NUM_EVENTS-1:0] = mask_q;
		OFS_RX_DATA:      rd_word = {23'h000000, eng_busy, rx_byte};
		OFS_OWN_ADDR:     rd_word[6:0] = own_addr_q;
		default:          rd_hit = 1'b0;
		endcase
	end

	// read data registered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// bus engine
	// ----------------------------------------------------------------
	// interactive bit taken live; software changes it only when idle
	assign cfg.enable      = ctrl_q[BIT_ENABLE];
	assign cfg.master      = ctrl_q[BIT_MASTER];
	assign cfg.gcall_en    = ctrl_q[BIT_GCALL];
	assign cfg.interactive = ctrl_q[BIT_INTERACTIVE];
	assign cfg.nack        = ctrl_q[BIT_NACK];
	assign cfg.own_addr    = own_addr_q;

	bus_slave_engine u_engine (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.cfg       (cfg),
		.clk_lvl   (clk_lvl),
		.data_lvl  (data_lvl),
		.data_pull (eng_pull),
		.events    (eng_events),
		.rx_byte_q (rx_byte),
		.busy_q    (eng_busy)
	);

	// ----------------------------------------------------------------
	// pin ownership
	// ----------------------------------------------------------------
	// override hands both lines to software; otherwise the engine owns
	// data and never holds the clock (no stretching in this block)
	always_comb begin
		if (ctrl_q[BIT_SW_OVERRIDE]) begin
			drive.clk_oe_n  = ctrl_q[BIT_CLK_OUT];
			drive.data_oe_n = ctrl_q[BIT_DATA_OUT];
		end else begin
			drive.clk_oe_n  = 1'b1;
			drive.data_oe_n = ~(eng_pull & ctrl_q[BIT_ENABLE]);
		end
	end
	assign clk_line_oe_n  = drive.clk_oe_n;
	assign data_line_oe_n = drive.data_oe_n;
	assign clk_line_o     = 1'b0; // open drain: only ever drives low
	assign data_line_o    = 1'b0;

endmodule
`default_nettype wire

// file: rtl/bus_slave_engine.sv
// bus_slave_engine: slave-side receive engine for the two-wire bus.
// assumes line levels already synchronised to aclk; drives the data
// pull request active high (high = pull line low).
`timescale 1ns/10ps
`default_nettype none
module bus_slave_engine (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire bus_ctl_pkg::engine_cfg_t cfg,
	input  wire logic                     clk_lvl,
	input  wire logic                     data_lvl,
	output logic                          data_pull,
	output logic [bus_ctl_pkg::NUM_EVENTS-1:0] events,
	output logic [7:0]                    rx_byte_q,
	output logic                          busy_q
);
	import bus_ctl_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_AACK = 3'b010,
		ST_DATA = 3'b011,
		ST_DACK = 3'b100,
		ST_SKIP = 3'b101
	} eng_state_t;

	eng_state_t state_q;
	logic       clk_prev_q;
	logic       data_prev_q;
	logic [7:0] shift_q;
	logic [3:0] bit_cnt_q;
	logic       pull_q;
	logic       rise;
	logic       fall;
	logic       start_c;
	logic       stop_c;
	logic       gcall_c;
	logic       hit_c;

	assign rise    = clk_lvl & ~clk_prev_q;
	assign fall    = ~clk_lvl & clk_prev_q;
	assign start_c = clk_lvl & clk_prev_q & data_prev_q & ~data_lvl;
	assign stop_c  = clk_lvl & clk_prev_q & ~data_prev_q & data_lvl;
	assign gcall_c = (shift_q[7:1] == 7'h00) & cfg.gcall_en;
	assign hit_c   = (shift_q[7:1] == cfg.own_addr) | gcall_c;
	assign data_pull = pull_q;

	// previous line levels for edge and start/stop detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_prev_q  <= 1'b1;
			data_prev_q <= 1'b1;
		end else begin
			clk_prev_q  <= clk_lvl;
			data_prev_q <= data_lvl;
		end
	end

	// receive sequencer; disabled or master role keeps it idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q   <= ST_IDLE;
			shift_q   <= 8'h00;
			bit_cnt_q <= 4'h0;
			pull_q    <= 1'b0;
			rx_byte_q <= 8'h00;
			events    <= '0;
			busy_q    <= 1'b0;
		end else begin
			events <= '0;
			if (!cfg.enable || cfg.master) begin
				state_q <= ST_IDLE;
				pull_q  <= 1'b0;
				busy_q  <= 1'b0;
			end else if (start_c) begin
				state_q   <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				pull_q    <= 1'b0;
				busy_q    <= 1'b1;
			end else if (stop_c) begin
				state_q <= ST_IDLE;
				pull_q  <= 1'b0;
				busy_q  <= 1'b0;
				if (busy_q)
					events[EV_STOP] <= 1'b1;
			end else begin
				case (state_q)
				ST_ADDR, ST_DATA: begin
					if (rise) begin
						shift_q   <= {shift_q[6:0], data_lvl};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (fall && bit_cnt_q == 4'h8) begin
						bit_cnt_q <= 4'h0;
						if (state_q == ST_ADDR) begin
							if (hit_c && !shift_q[0]) begin
								pull_q  <= 1'b1;
								state_q <= ST_AACK;
								events[gcall_c ? EV_GCALL_HIT
								       : EV_ADDR_HIT] <= 1'b1;
							end else begin
								state_q <= ST_SKIP;
							end
						end else begin
							rx_byte_q <= shift_q;
							// ack, or nack when both interactive and nack are set
							pull_q <= ~(cfg.interactive & cfg.nack);
							state_q <= ST_DACK;
							// per-byte event only in interactive mode
							if (cfg.interactive)
								events[EV_BYTE_RX] <= 1'b1;
						end
					end
				end
				ST_AACK, ST_DACK: begin
					if (fall) begin
						pull_q  <= 1'b0;
						state_q <= (state_q == ST_DACK && !pull_q)
						           ? ST_SKIP : ST_DATA;
					end
				end
				ST_SKIP, ST_IDLE: pull_q <= 1'b0;
				default: begin
					state_q <= ST_IDLE;
					pull_q  <= 1'b0;
				end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// file: tb/bus_control_asserts.sv
// bus_control_asserts: port-level checks for bus_control_top.
// assumes one aclk domain and one read in flight at a time.
`timescale 1ns/10ps
`default_nettype none
module bus_control_asserts #(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              s_axi_awvalid,
	input  wire logic              s_axi_awready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	input  wire logic              s_axi_arready,
	input  wire logic [31:0]       s_axi_rdata,
	input  wire logic [1:0]        s_axi_rresp,
	input  wire logic              s_axi_rvalid,
	input  wire logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic              clk_line_i,
	input  wire logic              clk_line_oe_n,
	input  wire logic              data_line_oe_n,
	input  wire logic              irq
);
	import bus_ctl_pkg::*;
	// ----------------------------------------------------------------
	// helper state
	// ----------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic       ar_ctrl_q;
	logic       clk_prev_q;
	logic [2:0] still_q;
	logic       ctrl_rd;
	logic       off_q;
	// remember whether the accepted read targets the control word
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ar_ctrl_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			ar_ctrl_q <= s_axi_araddr == ADDR_W'(OFS_CONTROL_WORD);
	end
	// cycles the clock line held still; sync latency needs a margin
	always_ff @(posedge aclk) begin
		clk_prev_q <= clk_line_i;
		if (!aresetn || clk_line_i != clk_prev_q)
			still_q <= 3'h0;
		else if (still_q != 3'h7)
			still_q <= still_q + 3'h1;
	end
	assign ctrl_rd = s_axi_rvalid && ar_ctrl_q && s_axi_rresp == RESP_OKAY;
	// last control read showed the block off; any write may change that,
	// so the flag drops as soon as a write address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_awvalid && s_axi_awready))
			off_q <= 1'b0;
		else if (ctrl_rd)
			off_q <= !s_axi_rdata[10] && !s_axi_rdata[0];
	end
	sequence ctrl_take;
		s_axi_arvalid && s_axi_arready &&
			s_axi_araddr == ADDR_W'(OFS_CONTROL_WORD);
	endsequence
	sw_clk_a: assert property (ctrl_rd && s_axi_rdata[10] |->
		clk_line_oe_n == s_axi_rdata[6]) else $error("clock pin not sw");
	sw_data_a: assert property (ctrl_rd && s_axi_rdata[10] |->
		data_line_oe_n == s_axi_rdata[7]) else $error("data pin not sw");
	hw_clk_a: assert property (ctrl_rd && !s_axi_rdata[10] |->
		clk_line_oe_n) else $error("clock pulled without override");
	idle_data_a: assert property (off_q |->
		data_line_oe_n && clk_line_oe_n) else $error("line pulled while off");
	master_rel_a: assert property (ctrl_rd && !s_axi_rdata[10] &&
		s_axi_rdata[1] |-> data_line_oe_n) else $error("master pulls data");
	clk_level_a: assert property ($rose(s_axi_rvalid) && ar_ctrl_q &&
		still_q >= 3'h6 |-> s_axi_rdata[8] == clk_line_i)
		else $error("clock level bit wrong");
	reset_rel_a: assert property ($rose(aresetn) |->
		(clk_line_oe_n && data_line_oe_n && !irq) [*3])
		else $error("lines or irq active after reset");
	ctrl_answer_a: assert property (ctrl_take |=>
		s_axi_rvalid && s_axi_rresp == RESP_OKAY) else $error("no read answer");
	resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) else $error("write response dropped");
endmodule
bind bus_control_top bus_control_asserts #(.ADDR_W(ADDR_W)) chk_i (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid,
	.s_axi_bready, .clk_line_i, .clk_line_oe_n, .data_line_oe_n, .irq);
`default_nettype wire

// file: tb/bus_control_top_tb.sv
// bus_control_top_tb: register and pin tests for bus_control_top.
// assumes the design package and the outside bus master model.
`timescale 1ns/10ps
`default_nettype none
module bus_control_top_tb;
	import bus_ctl_pkg::*;
	// ----------------------------------------------------------------
	// stimulus, tasks and tests
	// ----------------------------------------------------------------
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, clk_line_oe_n, data_line_oe_n, irq;
	logic        clk_pull, data_pull, clk_line_o, data_line_o;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int          n_errors = 0;
	int          checks_done = 0;
	// pull-ups: a line reads high unless some party pulls it
	wire clk_line_i = clk_line_oe_n & ~clk_pull;
	wire data_line_i = data_line_oe_n & ~data_pull;
	always #4 aclk = ~aclk;
	bus_control_top #(.ADDR_W(8)) dut (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .clk_line_i, .clk_line_o,
		.clk_line_oe_n, .data_line_i, .data_line_o, .data_line_oe_n, .irq);
	bus_line_model m (.data_w(data_line_i), .clk_pull, .data_pull);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// software keeps reserved bit 5 at zero in every write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, RESP_OKAY);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
			input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
	endtask
	task automatic finish_test();
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog: the tests need well under a third of this span
	initial begin
		repeat (30000) @(posedge aclk);
		n_errors++;
		finish_test();
	end
	initial begin
		logic [1:0] ack;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rc(OFS_CONTROL_WORD, 32'h300, RESP_OKAY);
		chk({clk_line_oe_n, data_line_oe_n, irq}, 3'b110);
		rc(8'h08, 32'h0, RESP_SLVERR);
		// software owns both lines: every pull and release pair
		for (int i = 0; i < 4; i++) begin
			wr(OFS_CONTROL_WORD, 32'h400 | 32'(i << 6));
			repeat (4) @(posedge aclk);
			chk({data_line_oe_n, clk_line_oe_n}, i);
			chk({clk_line_o, data_line_o}, 2'b00);
			rc(OFS_CONTROL_WORD, 32'h400 | 32'(i * 32'h140), RESP_OKAY);
		end
		wr(OFS_CONTROL_WORD, 32'h0);
		chk({data_line_oe_n, clk_line_oe_n}, 2'b11);
		rc(OFS_CONTROL_WORD, 32'h300, RESP_OKAY);
		m.frame(8'h54, 8'h5a, ack);
		chk(ack, 2'b11);
		wr(OFS_CONTROL_WORD, 32'h3);
		rc(OFS_CONTROL_WORD, 32'h303, RESP_OKAY);
		m.frame(8'h54, 8'h5a, ack);
		chk(ack, 2'b11);
		wr(OFS_CONTROL_WORD, 32'h1);
		wr(OFS_EVENT_MASK, 32'hf);
		m.frame(8'h54, 8'h5a, ack);
		chk(ack, 2'b00);
		rc(OFS_EVENT_STATUS, 32'ha, RESP_OKAY);
		rc(OFS_RX_DATA, 32'h5a, RESP_OKAY);
		chk(irq, 1'b1);
		wr(OFS_EVENT_MASK, 32'h0);
		chk(irq, 1'b0);
		wr(OFS_EVENT_MASK, 32'hf);
		chk(irq, 1'b1);
		wr(OFS_EVENT_STATUS, 32'hf);
		chk(irq, 1'b0);
		// general call ignored, then accepted
		for (int g = 0; g < 2; g++) begin
			wr(OFS_CONTROL_WORD, 32'h1 | 32'(g << 2));
			m.frame(8'h00, 8'h33, ack);
			chk(ack, {2{~g[0]}});
			rc(OFS_EVENT_STATUS, g ? 32'hc : 32'h8, RESP_OKAY);
			wr(OFS_EVENT_STATUS, 32'hf);
		end
		// bus idle here, so interactive mode may change
		for (int k = 0; k < 2; k++) begin
			wr(OFS_CONTROL_WORD, 32'h9 | 32'(k << 4));
			m.frame(8'h54, 8'ha5, ack);
			chk(ack, {1'b0, k[0]});
			rc(OFS_EVENT_STATUS, 32'hb, RESP_OKAY);
			wr(OFS_EVENT_STATUS, 32'hf);
		end
		finish_test();
	end
endmodule
`default_nettype wire

// file: tb/bus_line_model.sv
// bus_line_model: outside bus master that sends frames on the two lines.
// assumes pull-ups on both lines; the bench resolves the wired levels.
`timescale 1ns/10ps
`default_nettype none
module bus_line_model (
	input  wire logic data_w,
	output logic      clk_pull,
	output logic      data_pull
);
	// ----------------------------------------------------------------
	// frame generation
	// ----------------------------------------------------------------
	// clock stands still between frames, so nothing is pulled at idle
	initial begin
		clk_pull = 1'b0;
		data_pull = 1'b0;
	end
	// one slot: data moves mid-low, sampled at the end of the high half
	task automatic slot(input logic b, output logic seen);
		clk_pull = 1'b1;
		#31.25 data_pull = ~b;
		#31.25 clk_pull = 1'b0;
		#62.5 seen = data_w;
	endtask
	// start, address byte, data byte, stop; ack bits are 0 when pulled
	task automatic frame(input logic [7:0] adr, input logic [7:0] dat,
			output logic [1:0] ack);
		logic        s;
		logic [17:0] v;
		v = {adr, 1'b1, dat, 1'b1};
		data_pull = 1'b1;
		#62.5;
		for (int i = 17; i >= 0; i--) begin
			slot(v[i], s);
			if (i == 9) ack[1] = s;
			if (i == 0) ack[0] = s;
		end
		clk_pull = 1'b1;
		#31.25 data_pull = 1'b1;
		#31.25 clk_pull = 1'b0;
		#62.5 data_pull = 1'b0;
		#62.5;
	endtask
endmodule
`default_nettype wire
